//--- core/pmem_consts.svh
`ifndef PMEM_CONSTS_SVH
`define PMEM_CONSTS_SVH
// Operation
// - Program counter is 21 bits, byte addressing a 2 MB space.
// - Reads above implemented flash inside the space return zero.
// - Flash size is a parameter: 64 KB or 128 KB.
// - Every reset loads the program counter with vector zero.
// - High priority interrupts vector to 0008h, low priority to 0018h.
// - Top four words of flash hold configuration data.
// - Configuration words copied into registers at reset before use.
// - Config bytes ascending: first word low byte lowest address.
// - Loader reads top eight bytes: FFF8h or 1FFF8h.
// - Interrupt wake with a global enable pushes PC, bumps stack pointer; it holds at 1Fh.
// - Same wake loads the vector matching interrupt priority.
// - Interrupt wake leaves a request flag set showing its source.
// - Program and data buses separate, usable in the same cycle.
// - PC bit zero stays zero; sequential fetch adds two.
`define PC_W 21
`define PC_TOP 21'h1F_FFFF
`define RESET_VEC 21'h00_0000
`define HI_VEC 21'h00_0008
`define LO_VEC 21'h00_0018
`define FLASH_64K 32'h0001_0000
`define FLASH_128K 32'h0002_0000
`define CFG_SPAN 21'h00_0008
`define CFG_WORDS 4
`define SP_W 5
`define SP_MAX 5'h1F
`endif

//--- core/pmem_pkg.sv
package pmem_pkg;
   typedef logic [20:0] pc_t;
   typedef struct packed {
      logic valid;
      logic [20:0] addr;
   } fetch_req_s;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } fetch_rsp_s;
   typedef struct packed {
      logic [15:0] w4;
      logic [15:0] w3;
      logic [15:0] w2;
      logic [15:0] w1;
   } cfg_words_s;
   typedef enum logic [3:0] {
      ST_LOAD = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_RUN = 4'b0100,
      ST_SLEEP = 4'b1000
   } pm_state_e;
endpackage

//--- core/fetch_decode.sv
`include "pmem_consts.svh"
// Range check in front of the flash array
module fetch_decode #(
   parameter int FLASH_BYTES = `FLASH_128K
) (
   input wire logic [20:0] addr,
   input wire logic req,
   output logic in_range,
   output logic flash_rd
);
   localparam logic [20:0] TOP = 21'(FLASH_BYTES - 1);
   // Only addresses at or under the top touch the array
   assign in_range = (addr <= TOP);
   assign flash_rd = req && in_range;
endmodule

//--- core/pmem_map.sv
`include "pmem_consts.svh"
// Program memory map, hard vectors, config load and interrupt wake
module pmem_map #(
   parameter int FLASH_BYTES = `FLASH_64K
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire pmem_pkg::fetch_req_s data_req,
   input wire logic advance,
   input wire logic jump,
   input wire pmem_pkg::pc_t jump_addr,
   input wire logic sleep_req,
   input wire logic wake_irq,
   input wire logic wake_hi,
   input wire logic high_priority_global_int_enable,
   input wire logic low_priority_global_int_enable,
   input wire logic [15:0] flash_data,
   input wire logic [15:0] flash_data_b,
   output logic flash_rd,
   output pmem_pkg::pc_t flash_addr,
   output logic flash_rd_b,
   output pmem_pkg::pc_t flash_addr_b,
   output pmem_pkg::fetch_rsp_s fetch_rsp,
   output pmem_pkg::fetch_rsp_s data_rsp,
   output pmem_pkg::pc_t pc,
   output pmem_pkg::pc_t top_of_stack,
   output logic [4:0] return_stack_pointer,
   output pmem_pkg::cfg_words_s cfg,
   output logic cfg_valid,
   output logic wake_flag,
   output logic asleep
);
   import pmem_pkg::*;

   localparam logic [20:0] CFG_BASE = 21'(FLASH_BYTES) - `CFG_SPAN;
   localparam logic [20:0] TOP = 21'(FLASH_BYTES - 1);

   pm_state_e state_q;
   pc_t pc_q;
   pc_t tos_q;
   logic [4:0] sp_q;
   logic [1:0] cfg_idx_q;
   cfg_words_s cfg_q;
   logic cfg_valid_q;
   logic wake_flag_q;
   logic rd_q;
   pc_t rd_addr_q;
   logic pend_q;
   logic pend_zero_q;
   logic rdb_q;
   pc_t rdb_addr_q;
   logic pendb_q;
   logic pendb_zero_q;
   fetch_rsp_s rsp_q;
   fetch_rsp_s drsp_q;
   logic in_range;
   logic fetch_go;
   logic in_range_b;
   logic dec_rd_b;
   logic wake_take;

   assign wake_take = state_q == ST_SLEEP && wake_irq &&
      (high_priority_global_int_enable || low_priority_global_int_enable);

   // Range check for the instruction fetch address
   fetch_decode #(.FLASH_BYTES(FLASH_BYTES)) u_dec_i (
      .addr(pc_q),
      .req(state_q == ST_RUN),
      .in_range(in_range),
      .flash_rd(fetch_go)
   );

   // Independent range check for the data side table reads
   fetch_decode #(.FLASH_BYTES(FLASH_BYTES)) u_dec_d (
      .addr(data_req.addr),
      .req(data_req.valid),
      .in_range(in_range_b),
      .flash_rd(dec_rd_b)
   );

   // Sequencer: config load after reset, then run and sleep
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q <= ST_LOAD;
      end else begin
         case (state_q)
            ST_LOAD: state_q <= ST_WAIT;
            ST_WAIT: state_q <= (cfg_idx_q == 2'd3) ? ST_RUN : ST_LOAD;
            ST_RUN: state_q <= sleep_req ? ST_SLEEP : ST_RUN;
            ST_SLEEP: state_q <= wake_irq ? ST_RUN : ST_SLEEP;
            default: state_q <= ST_LOAD;
         endcase
      end
   end

   // Config word index, one flash word per load step
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg_idx_q <= 2'd0;
      end else if (state_q == ST_WAIT) begin
         cfg_idx_q <= cfg_idx_q + 2'd1;
      end
   end

   // Captured config words, lowest address to first word
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg_q <= '0;
         cfg_valid_q <= 1'b0;
      end else if (state_q == ST_WAIT) begin
         case (cfg_idx_q)
            2'd0: cfg_q.w1 <= flash_data;
            2'd1: cfg_q.w2 <= flash_data;
            2'd2: cfg_q.w3 <= flash_data;
            2'd3: cfg_q.w4 <= flash_data;
            default: cfg_q <= cfg_q;
         endcase
         cfg_valid_q <= (cfg_idx_q == 2'd3);
      end
   end

   // Program counter: reset vector, step, jump and wake vector
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pc_q <= `RESET_VEC;
      end else if (wake_take) begin
         pc_q <= wake_hi ? `HI_VEC : `LO_VEC;
      end else if (state_q == ST_RUN && jump) begin
         pc_q <= {jump_addr[20:1], 1'b0};
      end else if (state_q == ST_RUN && advance) begin
         pc_q <= pc_q + 21'd2;
      end
   end

   // Push of the interrupted program counter on wake
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tos_q <= '0;
         sp_q <= 5'd0;
      end else if (wake_take) begin
         tos_q <= pc_q;
         sp_q <= (sp_q == `SP_MAX) ? sp_q : sp_q + 5'd1;
      end
   end

   // Wake source flag stays set after an interrupt wake
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wake_flag_q <= 1'b0;
      end else if (state_q == ST_SLEEP && wake_irq) begin
         wake_flag_q <= 1'b1;
      end else if (sleep_req && state_q == ST_RUN) begin
         wake_flag_q <= 1'b0;
      end
   end

   // Instruction port request, config reads during load
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_q <= 1'b0;
         rd_addr_q <= '0;
         pend_q <= 1'b0;
         pend_zero_q <= 1'b0;
      end else if (state_q == ST_LOAD) begin
         rd_q <= 1'b1;
         rd_addr_q <= CFG_BASE + {18'd0, cfg_idx_q, 1'b0};
         pend_q <= 1'b0;
         pend_zero_q <= 1'b0;
      end else begin
         rd_q <= fetch_go;
         rd_addr_q <= pc_q;
         pend_q <= state_q == ST_RUN;
         pend_zero_q <= !in_range;
      end
   end

   // Instruction answer, zero for unimplemented space
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= pend_q;
         rsp_q.data <= pend_zero_q ? 16'h0000 : flash_data;
      end
   end

   // Data side port, runs alongside the fetch port
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdb_q <= 1'b0;
         rdb_addr_q <= '0;
         pendb_q <= 1'b0;
         pendb_zero_q <= 1'b0;
         drsp_q <= '0;
      end else begin
         rdb_q <= dec_rd_b;
         rdb_addr_q <= data_req.addr;
         pendb_q <= data_req.valid;
         pendb_zero_q <= !in_range_b;
         drsp_q.valid <= pendb_q;
         drsp_q.data <= pendb_zero_q ? 16'h0000 : flash_data_b;
      end
   end

   assign flash_rd = rd_q;
   assign flash_addr = rd_addr_q;
   assign flash_rd_b = rdb_q;
   assign flash_addr_b = rdb_addr_q;
   assign fetch_rsp = rsp_q;
   assign data_rsp = drsp_q;
   assign pc = pc_q;
   assign top_of_stack = tos_q;
   assign return_stack_pointer = sp_q;
   assign cfg = cfg_q;
   assign cfg_valid = cfg_valid_q;
   assign wake_flag = wake_flag_q;
   assign asleep = state_q[3]; // One-hot sleep bit, straight from the flop

   // Reset always lands on the reset vector
   reset_vec_a: assert property (@(posedge ref_clk)
      srst
      |=> pc_q == `RESET_VEC)
      else $error("pc not at reset vector");
   // Wake picks vector by priority
   wake_vector_a: assert property (@(posedge ref_clk)
      disable iff (srst) wake_take
      |=> pc_q == ($past(wake_hi) ? `HI_VEC : `LO_VEC))
      else $error("wrong wake vector");
   // Wake pushes the old pc
   wake_push_a: assert property (@(posedge ref_clk)
      disable iff (srst) wake_take
      |=> tos_q == $past(pc_q))
      else $error("pc not pushed");
   // Pointer advances on push below the top
   sp_bump_a: assert property (@(posedge ref_clk)
      disable iff (srst) wake_take && sp_q != `SP_MAX
      |=> sp_q == $past(sp_q) + 5'd1)
      else $error("stack pointer not advanced");
   // Pc stays even
   pc_even_a: assert property (@(posedge ref_clk)
      disable iff (srst)
      pc_q[0] == 1'b0)
      else $error("pc odd");
   // Sequential step adds two
   pc_step_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_RUN && advance && !jump
      |=> pc_q == $past(pc_q) + 21'd2)
      else $error("pc step wrong");
   // Out of range fetch never hits flash and yields zero
   zero_fill_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_RUN && pc_q > TOP
      |=> !rd_q ##1 rsp_q.data == 16'h0000)
      else $error("zero fill broken");
   // Config reads stay within the top eight bytes
   cfg_range_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_WAIT
      |-> rd_q && rd_addr_q >= CFG_BASE && rd_addr_q <= TOP)
      else $error("config read outside range");
   // Config valid whenever the core runs
   cfg_first_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_RUN
      |-> cfg_valid_q)
      else $error("run before config");
   // Wake flag set after interrupt wake
   wake_flag_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_SLEEP && wake_irq
      |=> wake_flag_q)
      else $error("wake flag missing");
   // Out of range data read never strobes and yields zero
   data_zero_a: assert property (@(posedge ref_clk)
      disable iff (srst) data_req.valid && !in_range_b
      |=> !rdb_q ##1 drsp_q.data == 16'h0000)
      else $error("data zero fill broken");
   // Every data request is answered two edges later
   data_answer_a: assert property (@(posedge ref_clk)
      disable iff (srst) data_req.valid
      |=> ##1 drsp_q.valid)
      else $error("data answer missing");
   // Jump loads the even target
   jump_load_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_RUN && jump
      |=> pc_q == ($past(jump_addr) & ~21'h1))
      else $error("jump target wrong");
   // Wake without an enable leaves pc and stack alone
   no_wake_keep_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_SLEEP && wake_irq && !wake_take
      |=> pc_q == $past(pc_q) && sp_q == $past(sp_q))
      else $error("wake without enable moved pc");
   // Config words hold once loaded
   cfg_hold_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_RUN
      |=> cfg_q == $past(cfg_q))
      else $error("config changed while running");
   // Fetch strobe only inside implemented flash
   fetch_strobe_a: assert property (@(posedge ref_clk)
      disable iff (srst) rd_q
      |-> rd_addr_q <= TOP)
      else $error("fetch strobe out of range");
   // Data strobe only inside implemented flash
   data_strobe_a: assert property (@(posedge ref_clk)
      disable iff (srst) rdb_q
      |-> rdb_addr_q <= TOP)
      else $error("data strobe out of range");
   // Config words read in ascending address order
   cfg_order_a: assert property (@(posedge ref_clk)
      disable iff (srst) state_q == ST_WAIT
      |-> rd_addr_q == CFG_BASE + {18'd0, cfg_idx_q, 1'b0})
      else $error("config read order wrong");
endmodule

//--- testbench/flash_model.sv
// Flash array port: word stands while the strobe is high
module flash_model (
   input wire logic ref_clk,
   input wire logic rd,
   input wire pmem_pkg::pc_t addr,
   output logic [15:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] last_q = 16'h0000;
   // Low byte at the even address; a released port shows the inverse
   assign data = rd ? (addr[16:1] ^ 16'h3c5a) : ~last_q;
   // Remember the last word so an idle port never repeats it
   always @(posedge ref_clk) begin
      if (rd) begin
         last_q <= addr[16:1] ^ 16'h3c5a;
      end
   end
endmodule

//--- testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmem_pkg::*;
   localparam int FB = 32'h0001_0000;
   logic ref_clk = 0, srst = 1, advance = 0, jump = 0, sleep_req = 0;
   logic wake_irq = 0, wake_hi = 0, hi_en = 0, lo_en = 0;
   fetch_req_s data_req = '0;
   pc_t jump_addr = '0, flash_addr, flash_addr_b, pc, top_of_stack, a, tos;
   logic [15:0] flash_data, flash_data_b;
   logic flash_rd, flash_rd_b, cfg_valid, wake_flag, asleep;
   fetch_rsp_s fetch_rsp, data_rsp;
   logic [4:0] return_stack_pointer;
   cfg_words_s cfg;
   int error_cnt = 0, num_checks = 0, i, k;
   logic [15:0] exp_q[$];
   pc_t tbl[4];
   always #2.5 ref_clk = ~ref_clk;
   pmem_map #(.FLASH_BYTES(FB)) DUT (.ref_clk(ref_clk), .srst(srst),
      .data_req(data_req), .advance(advance), .jump(jump),
      .jump_addr(jump_addr), .sleep_req(sleep_req), .wake_irq(wake_irq),
      .wake_hi(wake_hi), .high_priority_global_int_enable(hi_en),
      .low_priority_global_int_enable(lo_en), .flash_data(flash_data),
      .flash_data_b(flash_data_b), .flash_rd(flash_rd),
      .flash_addr(flash_addr), .flash_rd_b(flash_rd_b),
      .flash_addr_b(flash_addr_b), .fetch_rsp(fetch_rsp),
      .data_rsp(data_rsp), .pc(pc), .top_of_stack(top_of_stack),
      .return_stack_pointer(return_stack_pointer), .cfg(cfg),
      .cfg_valid(cfg_valid), .wake_flag(wake_flag), .asleep(asleep));
   flash_model fm_i (.ref_clk(ref_clk), .rd(flash_rd), .addr(flash_addr),
      .data(flash_data));
   flash_model fm_d (.ref_clk(ref_clk), .rd(flash_rd_b),
      .addr(flash_addr_b), .data(flash_data_b));
   // Expected word, zero above the implemented flash
   function automatic logic [15:0] word_at(pc_t x);
      return (x < FB) ? (x[16:1] ^ 16'h3c5a) : 16'h0000;
   endfunction
   task automatic chk(string n, logic [20:0] e, logic [20:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic stop_test();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Bounded wait for a settled level on a flag
   task automatic wait_lvl(ref logic s, input logic lvl);
      int j;
      for (j = 0; j < 60 && s !== lvl; j++) begin
         cyc(1);
         #1;
      end
      if (s !== lvl) begin
         error_cnt++;
         stop_test();
      end
   endtask
   task automatic do_jump(pc_t x);
      cyc(1);
      jump <= 1;
      jump_addr <= x;
      cyc(1);
      jump <= 0;
      #1 chk("pc_jump", x & ~21'h1, pc);
   endtask
   // Data port answers come out in request order
   always @(negedge ref_clk) begin
      if (data_rsp.valid === 1'b1) begin
         if (exp_q.size() == 0) chk("data_extra", 0, 1);
         else chk("data_rsp", exp_q.pop_front(), data_rsp.data);
      end
      if (flash_rd_b === 1'b1) chk("rd_b_range", 1, flash_addr_b < FB);
      if (flash_rd === 1'b1) chk("rd_i_range", 1, flash_addr < FB);
   end
   initial begin
      void'($urandom(32'h7abb));
      tbl = '{21'h00_1235, pc_t'(FB - 2), pc_t'(FB), 21'h1F_FFFF};
      cyc(6);
      srst <= 0;
      wait_lvl(cfg_valid, 1);
      for (k = 0; k < 4; k++) begin
         chk("cfg", word_at(pc_t'(FB - 8 + 2 * k)), cfg[16*k +: 16]);
      end
      chk("pc_run", 0, pc);
      cyc(1);
      advance <= 1;
      cyc(4);
      advance <= 0;
      #1 chk("pc_step", 21'h00_0008, pc);
      // Fetch in range, at the top word, and above flash
      for (i = 0; i < 4; i++) begin
         do_jump(tbl[i]);
         cyc(3);
         #1 chk("fetch", word_at(tbl[i] & ~21'h1), fetch_rsp.data);
         chk("flash_rd", tbl[i] < FB, flash_rd);
         chk("flash_addr", tbl[i] & ~21'h1, flash_addr);
      end
      // Back to back data reads while fetching
      do_jump(21'h00_0100);
      for (i = 0; i < 24; i++) begin
         cyc(1);
         a = pc_t'(($urandom % 2) ? $urandom % FB : $urandom) & ~21'h1;
         data_req <= '{valid: 1'b1, addr: a};
         exp_q.push_back(word_at(a));
      end
      cyc(1);
      data_req <= '0;
      cyc(2);
      #1 chk("fetch_conc", word_at(21'h00_0100), fetch_rsp.data);
      cyc(2);
      chk("data_left", 0, exp_q.size());
      // Wake high, wake low, wake with both enables off
      tos = '0;
      for (i = 0; i < 3; i++) begin
         a = 21'h00_0400 + 21'(16 * i);
         do_jump(a);
         cyc(1);
         sleep_req <= 1;
         cyc(1);
         sleep_req <= 0;
         wait_lvl(asleep, 1);
         chk("flag_clr", 0, wake_flag);
         cyc(1);
         wake_irq <= 1;
         wake_hi <= (i != 1);
         hi_en <= (i == 0);
         lo_en <= (i == 1);
         cyc(1);
         wake_irq <= 0;
         #1 chk("asleep", 0, asleep);
         if (i < 2) tos = a;
         chk("pc_wake", (i == 0) ? 21'h8 : (i == 1) ? 21'h18 : a, pc);
         chk("tos", tos, top_of_stack);
         chk("sp", (i == 0) ? 1 : 2, return_stack_pointer);
         if (i < 2) chk("wake_flag", 1, wake_flag);
      end
      cyc(1);
      srst <= 1;
      cyc(2);
      srst <= 0;
      #1 chk("pc_rst", 0, pc);
      chk("sp_rst", 0, return_stack_pointer);
      chk("tos_rst", 0, top_of_stack);
      wait_lvl(cfg_valid, 1);
      chk("cfg_reload", word_at(pc_t'(FB - 8)), cfg.w1);
      stop_test();
   end
endmodule
